// [rtl/cic_top.sv]
// Two cascaded interrupt controllers behind an APB slave with an acknowledge port.
`timescale 1ns/1ps

// What this block does
// - Secondary unit's request output feeds primary input two.
// - Primary decodes ports 20h-21h as master, secondary A0h-A1h as slave.
// - Primary input zero is timer zero, secondary input zero is the clock alarm.
// - Other primary inputs and secondary inputs come from request pins.
// - Each unit latches requests, held until service begins.
// - Each unit keeps in-service bits, several may be set.
// - Each unit has a mask register disabling any channels.
// - Resolver combines request, service and mask and raises the cpu output.
// - Priority rotation can change at any time without reinitialisation.
// - First acknowledge sets service bit, clears request, issues cascade code.
// - Slave compares cascade code with its identifier and supplies the vector.
// - Second acknowledge drives an eight-bit vector onto the data bus.
// - Vector top five bits from init word two, low three the channel.
// - Auto end mode clears the service bit after the second acknowledge, except the primary's input two bit on a cascaded acknowledge.
// - No request at first acknowledge gives the level seven vector.
// - After initialisation priority is fixed, input zero highest.
// - Even write with bit four starts init, next three odd writes load words.
// - Even write with bit four clear loads word two or three by bit three.
// - End command clears named bit or highest priority service bit.
module cic_top import cic_pkg::*; (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Request sources.
  input wire logic timer0_output,
  input wire logic rtc_irq,
  input wire logic [15:0] irq_pins,
  // Processor side.
  input wire logic irq_acknowledge_cycle,
  output logic cpu_irq_output,
  output logic [7:0] peripheral_data_bus,
  output logic peripheral_data_oe_n
);

  // ************************************************************
  // Pin synchronisers.
  // ************************************************************
  logic [16:0] s1_q, s2_q, s3_q;
  logic [16:0] raw;
  logic [16:0] pin_lvl_q;
  assign raw = {irq_acknowledge_cycle, rtc_irq, irq_pins[15:9], irq_pins[7:3], irq_pins[1],
                timer0_output, 1'b0};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_lvl_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 17; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_lvl_q[i] <= s3_q[i];
        end
      end
    end
  end
  logic ack_lvl;
  logic [6:0] pri_ext;
  assign ack_lvl = pin_lvl_q[16];
  assign pri_ext = pin_lvl_q[7:1];

  // ************************************************************
  // Helper functions.
  // ************************************************************
  function automatic logic [8:0] cic_pick(input logic [7:0] v, input logic [2:0] low);
    logic [8:0] r;
    logic [2:0] c;
    r = '0;
    for (int k = 7; k >= 0; k--) begin
      c = 3'(low + 3'(1) + 3'(k));
      if (v[c]) begin
        r = {1'b1, c, 5'h0};
      end
    end
    return r;
  endfunction : cic_pick

  // ************************************************************
  // Two controller units.
  // ************************************************************
  cic_regs_t u_q [2];
  logic [7:0] in_q [2];
  logic [7:0] prev_q [2];
  logic [4:0] vec_q [2];
  logic [2:0] id_q [2];
  logic [2:0] low_q [2];
  logic auto_service_end_mode_q [2];
  logic rot_auto_q [2];
  logic [1:0] step_q [2];
  logic ris_q [2];
  logic poll_q [2];
  logic [7:0] ins [2];
  logic [8:0] wreq [2];
  logic [8:0] wisr [2];
  logic unit_irq [2];

  assign ins[0] = {pri_ext[6:2], unit_irq[1], pri_ext[1], pin_lvl_q[1]};
  assign ins[1] = {pin_lvl_q[14:8], pin_lvl_q[15]};

  for (genvar g = 0; g < 2; g++) begin : g_res
    assign wreq[g] = cic_pick(u_q[g].req & ~u_q[g].mask, low_q[g]);
    assign wisr[g] = cic_pick(u_q[g].in_service_reg, low_q[g]);
    assign unit_irq[g] = wreq[g][8] && (!wisr[g][8] ||
      (3'(wreq[g][7:5] - low_q[g] - 3'(1)) < 3'(wisr[g][7:5] - low_q[g] - 3'(1))));
  end

  // ************************************************************
  // Acknowledge sequencing.
  // ************************************************************
  cic_ack_state_t ack_q;
  logic ack_prev_q;
  logic ack_rise, ack_fall;
  logic [2:0] chan_q;
  logic spur_q, casc_q;
  logic [2:0] wreq0_ch_q;
  assign ack_rise = ack_lvl && !ack_prev_q;
  assign ack_fall = !ack_lvl && ack_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= CIC_ACK_IDLE;
      ack_prev_q <= 1'b0;
      chan_q <= '0;
      spur_q <= 1'b0;
      casc_q <= 1'b0;
    end else begin
      ack_prev_q <= ack_lvl;
      case (ack_q)
        CIC_ACK_IDLE: begin
          if (ack_rise) begin
            ack_q <= CIC_ACK_FIRST;
            spur_q <= !unit_irq[0];
            casc_q <= unit_irq[0] && wreq[0][7:5] == CIC_CASCADE_CH;
            chan_q <= (unit_irq[0] && wreq[0][7:5] == CIC_CASCADE_CH) ? wreq[1][7:5] :
                      wreq[0][7:5];
          end
        end
        CIC_ACK_FIRST: begin
          if (ack_rise) begin
            ack_q <= CIC_ACK_SECOND;
          end
        end
        default: begin
          if (ack_fall) begin
            ack_q <= CIC_ACK_IDLE;
          end
        end
      endcase
    end
  end
  logic first_take;
  logic second_end;
  assign first_take = ack_q == CIC_ACK_IDLE && ack_rise;
  assign second_end = ack_q == CIC_ACK_SECOND && ack_fall;

  // ************************************************************
  // Register writes and per-unit state.
  // ************************************************************
  logic wr, rd;
  logic [1:0] hit;
  logic odd;
  logic [7:0] wd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign odd = paddr[2];
  assign wd = pwdata[7:0];
  always_comb begin
    if (paddr[11:3] == {1'b0, CIC_PRI_BASE}) begin
      hit = 2'b01;
    end else if (paddr[11:3] == {1'b0, CIC_SEC_BASE}) begin
      hit = 2'b10;
    end else begin
      hit = 2'b00;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_unit
    logic acked;
    logic [2:0] eoi_ch;
    logic ew, ow;
    assign ew = wr && hit[g] && !odd;
    assign ow = wr && hit[g] && odd;
    // a cascaded slave acts only when the master code equals its identifier.
    assign acked = first_take && !spur_q_next() && (g == 0 ? 1'b1 :
                   (casc_next() && id_q[1] == CIC_CASCADE_CH));
    assign eoi_ch = (wd[CIC_BIT_SPECIFIC]) ? wd[2:0] : wisr[g][7:5];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        u_q[g] <= '{req: 8'h0, in_service_reg: 8'h0, mask: CIC_RESET_MASK};
        prev_q[g] <= '0;
      end else begin
        prev_q[g] <= ins[g];
        // set wins over clear by the acknowledge.
        u_q[g].req <= (u_q[g].req & ~((acked ? 8'h1 : 8'h0) << cur_ch(g))) |
                      (ins[g] & ~prev_q[g]);
        if (acked) begin
          u_q[g].in_service_reg[cur_ch(g)] <= 1'b1;
        end else if (second_end && auto_service_end_mode_q[g] && (g == 0 ? !casc_q : casc_q) && !spur_q) begin
          u_q[g].in_service_reg[g == 0 ? wreq0_ch_q : chan_q] <= 1'b0;
        end else if (ew && !wd[CIC_BIT_INIT] && !wd[CIC_BIT_OW3] && wd[CIC_BIT_EOI]) begin
          u_q[g].in_service_reg[eoi_ch] <= 1'b0;
        end
        if (ew && wd[CIC_BIT_INIT]) begin
          u_q[g].mask <= 8'h0;
        end else if (ow && step_q[g] == CIC_RESET_STEP) begin
          u_q[g].mask <= wd;
        end
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        step_q[g] <= CIC_RESET_STEP;
        vec_q[g] <= '0;
        id_q[g] <= CIC_RESET_ID;
        auto_service_end_mode_q[g] <= 1'b0;
        low_q[g] <= 3'h7;
        rot_auto_q[g] <= 1'b0;
        ris_q[g] <= 1'b0;
        poll_q[g] <= 1'b0;
      end else begin
        if (ew && wd[CIC_BIT_INIT]) begin
          step_q[g] <= 2'h1;
          low_q[g] <= 3'h7;
          id_q[g] <= CIC_RESET_ID;
          ris_q[g] <= 1'b0;
          rot_auto_q[g] <= 1'b0;
        end else if (ow && step_q[g] != CIC_RESET_STEP) begin
          step_q[g] <= 2'(step_q[g] + 2'h1);
          if (step_q[g] == 2'h1) begin
            vec_q[g] <= wd[7:3];
          end else if (step_q[g] == 2'h2) begin
            id_q[g] <= wd[2:0];
          end else begin
            auto_service_end_mode_q[g] <= wd[CIC_BIT_AUTO_END];
          end
        end else if (ew) begin
          step_q[g] <= CIC_RESET_STEP;
          if (wd[CIC_BIT_OW3]) begin
            if (wd[CIC_BIT_RR]) begin
              ris_q[g] <= wd[CIC_BIT_RIS];
            end
            poll_q[g] <= wd[CIC_BIT_POLL];
          end else if (wd[CIC_BIT_ROTATE]) begin
            rot_auto_q[g] <= !wd[CIC_BIT_SPECIFIC] && !wd[CIC_BIT_EOI];
            if (wd[CIC_BIT_SPECIFIC] || wd[CIC_BIT_EOI]) begin
              low_q[g] <= eoi_ch;
            end
          end else if (!wd[CIC_BIT_SPECIFIC] && !wd[CIC_BIT_EOI]) begin
            rot_auto_q[g] <= 1'b0;
          end
        end else if (rd && penable && hit[g] && !odd) begin
          poll_q[g] <= 1'b0;
        end else if (second_end && auto_service_end_mode_q[g] && rot_auto_q[g] && !spur_q &&
                     (g == 0 ? !casc_q : casc_q)) begin
          low_q[g] <= (g == 0) ? wreq0_ch_q : chan_q;
        end
      end
    end
  end

  // Channel taken at the first acknowledge, before the state register updates.
  function automatic logic [2:0] cur_ch(input int u);
    return wreq[u][7:5];
  endfunction : cur_ch
  function automatic logic spur_q_next();
    return !unit_irq[0];
  endfunction : spur_q_next
  function automatic logic casc_next();
    return wreq[0][7:5] == CIC_CASCADE_CH;
  endfunction : casc_next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreq0_ch_q <= '0;
    end else if (first_take) begin
      wreq0_ch_q <= wreq[0][7:5];
    end
  end

  // ************************************************************
  // Processor outputs.
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_irq_output <= 1'b0;
      peripheral_data_bus <= '0;
      peripheral_data_oe_n <= 1'b1;
    end else begin
      cpu_irq_output <= unit_irq[0];
      peripheral_data_oe_n <= 1'b1;
      if (ack_q == CIC_ACK_SECOND) begin
        peripheral_data_oe_n <= 1'b0;
        if (spur_q) begin
          peripheral_data_bus <= {vec_q[0], CIC_SPURIOUS_CH};
        end else if (casc_q) begin
          peripheral_data_bus <= {vec_q[1], chan_q};
        end else begin
          peripheral_data_bus <= {vec_q[0], wreq0_ch_q};
        end
      end
    end
  end

  // ************************************************************
  // APB read path.
  // ************************************************************
  logic rs;
  assign rs = hit[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (hit == 2'b00) begin
        prdata <= '0;
      end else if (odd) begin
        prdata <= {24'h0, u_q[rs].mask};
      end else if (poll_q[rs]) begin
        prdata <= {24'h0, unit_irq[rs], 4'h0, wreq[rs][7:5]};
      end else if (ris_q[rs]) begin
        prdata <= {24'h0, u_q[rs].in_service_reg};
      end else begin
        prdata <= {24'h0, u_q[rs].req};
      end
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && hit == 2'b00;

  // ************************************************************
  // Checks.
  // ************************************************************
  chk_vector_low_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (ack_q == CIC_ACK_SECOND && spur_q) |=> peripheral_data_bus[2:0] == CIC_SPURIOUS_CH)
    else $error("Spurious vector not level seven.");
  chk_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    unit_irq[0] |=> cpu_irq_output)
    else $error("Interrupt output did not follow resolver.");
  chk_bus_released: assert property (@(posedge pclk) disable iff (!presetn)
    (ack_q == CIC_ACK_IDLE) |=> peripheral_data_oe_n)
    else $error("Data bus driven outside acknowledge.");
  chk_init_mask_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit[0] && !odd && wd[CIC_BIT_INIT]) |=> u_q[0].mask == 8'h0)
    else $error("Init did not clear mask.");
  chk_init_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit[0] && !odd && wd[CIC_BIT_INIT]) |=> low_q[0] == 3'h7)
    else $error("Init did not restore fixed priority.");
  chk_ack_sets_isr: assert property (@(posedge pclk) disable iff (!presetn)
    (first_take && unit_irq[0]) |=> u_q[0].in_service_reg[$past(wreq[0][7:5])])
    else $error("First acknowledge did not set service bit.");
  chk_vector_base: assert property (@(posedge pclk) disable iff (!presetn)
    (ack_q == CIC_ACK_SECOND && !casc_q) |=> peripheral_data_bus[7:3] == vec_q[0])
    else $error("Vector base wrong.");
  chk_cascade_wire: assert property (@(posedge pclk) disable iff (!presetn)
    ins[0][2] == unit_irq[1])
    else $error("Cascade input not wired.");

endmodule : cic_top

// [rtl/cic_pkg.sv]
// Package with constants and carrier types for the cascaded interrupt controller.
package cic_pkg;

  // ************************************************************
  // Port decode and command word layout.
  // ************************************************************
  localparam logic [7:0] CIC_PRI_BASE = 8'h20;
  localparam logic [7:0] CIC_SEC_BASE = 8'ha0;
  localparam int CIC_BIT_INIT = 4;
  localparam int CIC_BIT_OW3 = 3;
  localparam int CIC_BIT_AUTO_END = 1;
  localparam int CIC_BIT_ROTATE = 7;
  localparam int CIC_BIT_SPECIFIC = 6;
  localparam int CIC_BIT_EOI = 5;
  localparam int CIC_BIT_RR = 1;
  localparam int CIC_BIT_RIS = 0;
  localparam int CIC_BIT_POLL = 2;
  localparam logic [2:0] CIC_CASCADE_CH = 3'h2;
  localparam logic [2:0] CIC_SPURIOUS_CH = 3'h7;
  localparam logic [2:0] CIC_RESET_ID = 3'h7;
  localparam logic [7:0] CIC_RESET_MASK = 8'hff;
  localparam logic [1:0] CIC_RESET_STEP = 2'h0;

  // ************************************************************
  // Types.
  // ************************************************************
  typedef enum logic [1:0] {
    CIC_ACK_IDLE = 2'b00,
    CIC_ACK_FIRST = 2'b01,
    CIC_ACK_SECOND = 2'b11
  } cic_ack_state_t;

  typedef struct packed {
    logic [7:0] req;
    logic [7:0] in_service_reg;
    logic [7:0] mask;
  } cic_regs_t;

endpackage : cic_pkg

// [tb/cic_cpu_model.sv]
// Processor model that answers the interrupt output with two acknowledge pulses.
`timescale 1ns/1ps

module cic_cpu_model (
  // Clock and control from the bench.
  input wire logic pclk,
  input wire logic go,
  input wire logic force_ack,
  input wire logic [3:0] hold,
  // Processor pins.
  input wire logic cpu_irq_output,
  input wire logic [7:0] peripheral_data_bus,
  input wire logic peripheral_data_oe_n,
  output logic irq_acknowledge_cycle,
  // Captured vector.
  output logic [7:0] vector_seen,
  output logic done
);
  // ************************************************************
  // Acknowledge sequence.
  // ************************************************************
  initial begin
    irq_acknowledge_cycle = 1'b0;
    done = 1'b0;
    forever begin
      @(posedge pclk);
      if (go && !done && (cpu_irq_output || force_ack)) begin
        repeat (2) begin
          irq_acknowledge_cycle <= 1'b1;
          repeat (hold) @(posedge pclk);
          irq_acknowledge_cycle <= 1'b0;
          repeat (hold) @(posedge pclk);
        end
        done <= 1'b1;
      end else if (!go) begin
        done <= 1'b0;
      end
    end
  end

  // The bus is only read while the controller drives it.
  initial vector_seen = 8'h00;
  always @(posedge pclk) begin
    if (!peripheral_data_oe_n) begin
      vector_seen <= peripheral_data_bus;
    end
  end
endmodule : cic_cpu_model

// [tb/test_cic_top.sv]
// Self-checking testbench for the cascaded interrupt controller.
`timescale 1ns/1ps

module test_cic_top;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, cpu_irq_output;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic timer0_output, rtc_irq, irq_acknowledge_cycle, peripheral_data_oe_n, errv;
  logic [15:0] irq_pins;
  logic [7:0] peripheral_data_bus, vector_seen;
  logic go, force_ack, done;
  logic [3:0] hold;
  int mismatches = 0;
  int checks_done = 0;

  cic_top u_cic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer0_output(timer0_output), .rtc_irq(rtc_irq),
    .irq_pins(irq_pins), .irq_acknowledge_cycle(irq_acknowledge_cycle),
    .cpu_irq_output(cpu_irq_output), .peripheral_data_bus(peripheral_data_bus),
    .peripheral_data_oe_n(peripheral_data_oe_n));

  cic_cpu_model u_cic_cpu_model (.pclk(pclk), .go(go), .force_ack(force_ack),
    .hold(hold), .cpu_irq_output(cpu_irq_output),
    .peripheral_data_bus(peripheral_data_bus),
    .peripheral_data_oe_n(peripheral_data_oe_n),
    .irq_acknowledge_cycle(irq_acknowledge_cycle), .vector_seen(vector_seen),
    .done(done));

  // ************************************************************
  // Tasks.
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rdv, exp);
  endtask : rd_chk

  task automatic init(input logic [11:0] a, input logic [7:0] w2, w3, w4);
    wr(a, 8'h11);
    wr(a + 12'h004, w2);
    wr(a + 12'h004, w3);
    wr(a + 12'h004, w4);
  endtask : init

  task automatic ack_chk(input logic [7:0] exp, input logic [3:0] h);
    int n = 0;
    hold <= h;
    go <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (done !== 1'b1 && n < 300);
    if (n >= 300) mismatches++;
    check({24'h000000, vector_seen}, {24'h000000, exp});
    go <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : ack_chk

  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask : settle

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // ************************************************************
  // Clock, watchdog and tests.
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {presetn, psel, penable, pwrite, timer0_output, rtc_irq, go, force_ack} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    irq_pins = 16'h0000;
    hold = 4'h4;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(12'h100, 32'h00000000);
    rd_chk(12'h104, 32'h000000ff);
    apb(1'b0, 12'h200, 32'h00000000);
    check(errv, 1'b1);
    init(12'h100, 8'h08, 8'h04, 8'h01);
    init(12'h500, 8'h70, 8'h02, 8'h03);
    rd_chk(12'h104, 32'h00000000);
    wr(12'h104, 8'h28);
    irq_pins <= 16'h0028;
    settle();
    check(cpu_irq_output, 1'b0);
    check(peripheral_data_oe_n, 1'b1);
    wr(12'h104, 8'h00);
    settle();
    check(cpu_irq_output, 1'b1);
    rd_chk(12'h100, 32'h00000028);
    ack_chk(8'h0b, 4'h4);
    rd_chk(12'h100, 32'h00000020);
    wr(12'h100, 8'h0b);
    rd_chk(12'h100, 32'h00000008);
    check(cpu_irq_output, 1'b0);
    wr(12'h100, 8'h20);
    ack_chk(8'h0d, 4'h8);
    rd_chk(12'h100, 32'h00000020);
    wr(12'h100, 8'h65);
    rd_chk(12'h100, 32'h00000000);
    force_ack <= 1'b1;
    ack_chk(8'h0f, 4'h4);
    force_ack <= 1'b0;
    irq_pins <= 16'h0000;
    wr(12'h100, 8'hc4);
    irq_pins <= 16'h0028;
    settle();
    ack_chk(8'h0d, 4'h4);
    wr(12'h100, 8'h65);
    ack_chk(8'h0b, 4'h4);
    wr(12'h100, 8'h63);
    wr(12'h100, 8'hc7);
    irq_pins <= 16'h0002;
    timer0_output <= 1'b1;
    ack_chk(8'h08, 4'h4);
    wr(12'h100, 8'h20);
    ack_chk(8'h09, 4'h4);
    wr(12'h100, 8'h20);
    timer0_output <= 1'b0;
    irq_pins <= 16'h1000;
    ack_chk(8'h74, 4'h4);
    wr(12'h500, 8'h0b);
    rd_chk(12'h500, 32'h00000000);
    rd_chk(12'h100, 32'h00000004);
    wr(12'h100, 8'h20);
    rtc_irq <= 1'b1;
    ack_chk(8'h70, 4'h6);
    wr(12'h100, 8'h20);
    tally_and_finish();
  end
endmodule : test_cic_top
